/* File: common/dwsc_regs.svh */
// Purpose: Register map, field positions, reset values and timing counts
//          of the discontinuous-receive wake sequencer.
// Assumes: A 40 MHz system clock.
// Notes:   Definitions only; included by bare name.
//
// Functional notes
// - When the off period ends in discontinuous mode, pull the wake line low.
// - Hold wake line low during CPU recovery; its end starts the RF settle count.
// - CPU recovery count loads from 8-bit register 0x6, in 120 us ticks.
// - CPU recovery register resets to zero; host programs it before using DISCONTINUOUS_RECEIVE.
// - RF settle start powers all selected modules except the peak detectors.
// - RF settle end releases wake line, enables data outputs and peak detectors.
// - If host leaves wake line high, stay powered down and restart off period; the code powers the modules in ON until it sees the rise.
// - A high wake line in discontinuous mode restarts the sequence at off period.
// - RF settle count is 16 bits, upper at 0x7, lower at 0x8, 120 us ticks.
// - Both RF settle registers reset to zero; host programs them before use.
// - Power enable bits 7..1 enable modules; bit 0 selects deep sleep; reset 0.
// - Configuration bit 0 selects discontinuous (1) or continuous (0) receive.
// - Configuration bit 6 sets LNA gain, resets to 1; manual gain via AGC.
// - Configuration bit 5 selects accurate (1) or quick (0) frequency cal.
// - Configuration bits 4 and 3 turn data pins into serial read outputs.
// - Configuration bits 2 and 1 are the off-period tick prescale code.
// - Control bit 6 freezes the LNA gain in its present state.
// - Control bits 3 and 2 put the peak detectors into tracking mode.
// - Control bit 1 starts polling timer calibration; clears itself when done.
// - Control bit 0 starts frequency calibration; clears itself when done.
// - A serial write of word 0x3000 resets the device registers.
// - Status bits 1 and 0 read 1 once the matching calibration has completed.
// - Off-period count is 16 bits at 0x4 and 0x5, scaled by the prescale tick.
`ifndef DWSC_REGS_SVH
`define DWSC_REGS_SVH

`define DWSC_ADDR_POWER 4'h0
`define DWSC_ADDR_CONFIG 4'h1
`define DWSC_ADDR_CONTROL 4'h2
`define DWSC_ADDR_OSC 4'h3
`define DWSC_ADDR_OFF_HI 4'h4
`define DWSC_ADDR_OFF_LO 4'h5
`define DWSC_ADDR_CPU 4'h6
`define DWSC_ADDR_RF_HI 4'h7
`define DWSC_ADDR_RF_LO 4'h8
`define DWSC_ADDR_STATUS 4'h9

`define DWSC_RST_POWER 8'h00
`define DWSC_RST_CONFIG 8'h40
`define DWSC_RST_CONTROL 8'h00
`define DWSC_RST_ZERO 8'h00

`define DWSC_CFG_GAIN 6
`define DWSC_CFG_ACCCAL 5
`define DWSC_CFG_FOUT 4
`define DWSC_CFG_AOUT 3
`define DWSC_CFG_PS_HI 2
`define DWSC_CFG_PS_LO 1
`define DWSC_CFG_DRX 0
`define DWSC_CTL_FREEZE 6
`define DWSC_CTL_FTRK 3
`define DWSC_CTL_ATRK 2
`define DWSC_CTL_PCAL 1
`define DWSC_CTL_FCAL 0
`define DWSC_PWR_SLEEP 0
`define DWSC_ST_GAIN 6
`define DWSC_ST_PDONE 1
`define DWSC_ST_FDONE 0

`define DWSC_CMD_WRITE 4'h1
`define DWSC_CMD_READ 4'h2
`define DWSC_CMD_RESET 4'h3
`define DWSC_FRAME_BITS 5'd16
`define DWSC_HEAD_BITS 5'd8

`define DWSC_CLK_MHZ 40
`define DWSC_TICK_US 120
`define DWSC_TICK_CYCLES (`DWSC_TICK_US * `DWSC_CLK_MHZ)
`define DWSC_QCAL_CYCLES 2000
`define DWSC_ACAL_CYCLES 16000
`define DWSC_PCAL_CYCLES 8000

`endif

/* File: common/dwsc_pkg.sv */
// Purpose: Types shared by the wake sequencer design.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Numbers live in dwsc_regs.svh.
package dwsc_pkg;

  typedef enum logic [2:0] {
    DWSC_IDLE = 3'b000,
    DWSC_OFF = 3'b001,
    DWSC_CPU = 3'b010,
    DWSC_RF = 3'b011,
    DWSC_ON = 3'b100
  } dwsc_state_type;

  // Module power enables, most significant first as in the power register.
  typedef struct packed {
    logic low_noise_amp_on;
    logic auto_gain_on;
    logic mixer_on;
    logic freq_baseband_on;
    logic freq_peak_detect_on;
    logic amp_baseband_on;
    logic amp_peak_detect_on;
  } dwsc_power_type;

  typedef struct packed {
    logic gain_freeze;
    logic freq_detector_tracking;
    logic amp_detector_tracking;
    logic lna_gain_high;
    logic accurate_freq_cal_select;
  } dwsc_analog_ctl_type;

endpackage : dwsc_pkg

/* File: rtl/dwsc_top.sv */
// Purpose: Discontinuous-receive wake sequencer with its serial registers.
// Assumes: Serial clock well below the 40 MHz system clock.
// Notes:   The wake line doubles as the serial data line.
`timescale 1ns/1ps
`include "dwsc_regs.svh"

module dwsc_top #(
  parameter int TICK_CYCLES = `DWSC_TICK_CYCLES,
  parameter int QCAL_CYCLES = `DWSC_QCAL_CYCLES,
  parameter int ACAL_CYCLES = `DWSC_ACAL_CYCLES,
  parameter int PCAL_CYCLES = `DWSC_PCAL_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic wake_handshake_line_in,
  output logic wake_handshake_line_out,
  output logic wake_handshake_line_oe_out,
  input wire logic amp_demod_in,
  input wire logic freq_demod_in,
  input wire logic agc_gain_high_in,
  output logic amplitude_data_pin_out,
  output logic amplitude_data_pin_oe_out,
  output logic frequency_data_pin_out,
  output logic frequency_data_pin_oe_out,
  output dwsc_pkg::dwsc_power_type power_out,
  output logic deep_sleep_out,
  output dwsc_pkg::dwsc_analog_ctl_type analog_ctl_out,
  output logic [7:0] osc_freq_out
);
  import dwsc_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Index 0 serial clock, 1 chip select, 2 wake line.
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] stab_q;
  logic [2:0] pin_chg;

  assign pin_raw = {wake_handshake_line_in, chip_select_n_in, serial_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      assign pin_chg[gi] = (sync2_q[gi] == sync3_q[gi]) &&
                           (sync3_q[gi] != stab_q[gi]);
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
          stab_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (pin_chg[gi]) begin
            stab_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic wake_rise;
  assign sclk_rise = pin_chg[0] & sync3_q[0];
  assign sclk_fall = pin_chg[0] & ~sync3_q[0];
  assign cs_rise = pin_chg[1] & sync3_q[1];
  assign cs_fall = pin_chg[1] & ~sync3_q[1];
  assign wake_rise = pin_chg[2] & sync3_q[2];

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  logic [15:0] sh_q;
  logic [4:0] bits_q;
  logic rd_act_q;
  logic [7:0] rd_sh_q;
  logic rd_bit_q;
  logic wr_stb;
  logic soft_rst;
  logic [7:0] rd_data;

  logic [7:0] power_q;
  logic [7:0] config_q;
  logic [7:0] control_q;
  logic [7:0] osc_q;
  logic [7:0] off_hi_q;
  logic [7:0] off_lo_q;
  logic [7:0] cpu_q;
  logic [7:0] rf_hi_q;
  logic [7:0] rf_lo_q;
  logic pdone_q;
  logic fdone_q;
  logic gain_q;

  // A frame counts once sixteen bits have arrived before release; any later bits are not shifted in.
  assign wr_stb = cs_rise && (bits_q == `DWSC_FRAME_BITS) &&
                  (sh_q[15:12] == `DWSC_CMD_WRITE);
  assign soft_rst = cs_rise && (bits_q == `DWSC_FRAME_BITS) &&
                    (sh_q == 16'h3000);

  always_comb begin
    unique case (sh_q[3:0])
      `DWSC_ADDR_POWER: rd_data = power_q;
      `DWSC_ADDR_CONFIG: rd_data = config_q;
      `DWSC_ADDR_CONTROL: rd_data = control_q;
      `DWSC_ADDR_OSC: rd_data = osc_q;
      `DWSC_ADDR_OFF_HI: rd_data = off_hi_q;
      `DWSC_ADDR_OFF_LO: rd_data = off_lo_q;
      `DWSC_ADDR_CPU: rd_data = cpu_q;
      `DWSC_ADDR_RF_HI: rd_data = rf_hi_q;
      `DWSC_ADDR_RF_LO: rd_data = rf_lo_q;
      `DWSC_ADDR_STATUS: begin
        rd_data = 8'h00;
        rd_data[`DWSC_ST_GAIN] = gain_q;
        rd_data[`DWSC_ST_PDONE] = pdone_q;
        rd_data[`DWSC_ST_FDONE] = fdone_q;
      end
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sh_q <= 16'h0000;
      bits_q <= 5'd0;
      rd_act_q <= 1'b0;
      rd_sh_q <= 8'h00;
      rd_bit_q <= 1'b0;
    end else if (cs_fall) begin
      bits_q <= 5'd0;
      rd_act_q <= 1'b0;
    end else if (cs_rise) begin
      rd_act_q <= 1'b0;
    end else if (!stab_q[1]) begin
      if (sclk_rise && bits_q != `DWSC_FRAME_BITS) begin
        sh_q <= {sh_q[14:0], stab_q[2]};
        bits_q <= bits_q + 5'd1;
      end
      // Header complete: the read answer goes out on the next eight bits.
      if (bits_q == `DWSC_HEAD_BITS && !rd_act_q &&
          sh_q[7:4] == `DWSC_CMD_READ) begin
        rd_act_q <= 1'b1;
        rd_sh_q <= rd_data;
      end
      if (sclk_fall && rd_act_q) begin
        rd_bit_q <= rd_sh_q[7];
        rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic pcal_end;
  logic fcal_end;
  assign wr_addr = sh_q[11:8];
  assign wr_data = sh_q[7:0];

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      power_q <= `DWSC_RST_POWER;
      config_q <= `DWSC_RST_CONFIG;
      osc_q <= `DWSC_RST_ZERO;
      off_hi_q <= `DWSC_RST_ZERO;
      off_lo_q <= `DWSC_RST_ZERO;
      cpu_q <= `DWSC_RST_ZERO;
      rf_hi_q <= `DWSC_RST_ZERO;
      rf_lo_q <= `DWSC_RST_ZERO;
    end else if (soft_rst) begin
      power_q <= `DWSC_RST_POWER;
      config_q <= `DWSC_RST_CONFIG;
      osc_q <= `DWSC_RST_ZERO;
      off_hi_q <= `DWSC_RST_ZERO;
      off_lo_q <= `DWSC_RST_ZERO;
      cpu_q <= `DWSC_RST_ZERO;
      rf_hi_q <= `DWSC_RST_ZERO;
      rf_lo_q <= `DWSC_RST_ZERO;
    end else if (wr_stb) begin
      unique case (wr_addr)
        `DWSC_ADDR_POWER: power_q <= wr_data;
        `DWSC_ADDR_CONFIG: config_q <= wr_data;
        `DWSC_ADDR_OSC: osc_q <= wr_data;
        `DWSC_ADDR_OFF_HI: off_hi_q <= wr_data;
        `DWSC_ADDR_OFF_LO: off_lo_q <= wr_data;
        `DWSC_ADDR_CPU: cpu_q <= wr_data;
        `DWSC_ADDR_RF_HI: rf_hi_q <= wr_data;
        `DWSC_ADDR_RF_LO: rf_lo_q <= wr_data;
        default: ;
      endcase
    end
  end

  // A fresh start written in the finishing cycle wins over the self-clear.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      control_q <= `DWSC_RST_CONTROL;
    end else if (soft_rst) begin
      control_q <= `DWSC_RST_CONTROL;
    end else if (wr_stb && wr_addr == `DWSC_ADDR_CONTROL) begin
      control_q <= wr_data;
    end else begin
      if (pcal_end) begin
        control_q[`DWSC_CTL_PCAL] <= 1'b0;
      end
      if (fcal_end) begin
        control_q[`DWSC_CTL_FCAL] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Calibration engines
  // ****************************************************************
  logic [15:0] pcal_cnt_q;
  logic [15:0] fcal_cnt_q;
  logic pcal_run_q;
  logic fcal_run_q;
  assign pcal_end = pcal_run_q && pcal_cnt_q == 16'h0000;
  assign fcal_end = fcal_run_q && fcal_cnt_q == 16'h0000;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pcal_run_q <= 1'b0;
      pcal_cnt_q <= 16'h0000;
      pdone_q <= 1'b0;
    end else if (soft_rst) begin
      pcal_run_q <= 1'b0;
      pdone_q <= 1'b0;
    end else if (control_q[`DWSC_CTL_PCAL] && !pcal_run_q) begin
      pcal_run_q <= 1'b1;
      pcal_cnt_q <= 16'(PCAL_CYCLES - 1);
      pdone_q <= 1'b0;
    end else if (pcal_end) begin
      pcal_run_q <= 1'b0;
      pdone_q <= 1'b1;
    end else if (pcal_run_q) begin
      pcal_cnt_q <= pcal_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fcal_run_q <= 1'b0;
      fcal_cnt_q <= 16'h0000;
      fdone_q <= 1'b0;
    end else if (soft_rst) begin
      fcal_run_q <= 1'b0;
      fdone_q <= 1'b0;
    end else if (control_q[`DWSC_CTL_FCAL] && !fcal_run_q) begin
      fcal_run_q <= 1'b1;
      fdone_q <= 1'b0;
      if (config_q[`DWSC_CFG_ACCCAL]) begin
        fcal_cnt_q <= 16'(ACAL_CYCLES - 1);
      end else begin
        fcal_cnt_q <= 16'(QCAL_CYCLES - 1);
      end
    end else if (fcal_end) begin
      fcal_run_q <= 1'b0;
      fdone_q <= 1'b1;
    end else if (fcal_run_q) begin
      fcal_cnt_q <= fcal_cnt_q - 16'h0001;
    end
  end

  // ****************************************************************
  // Tick divider and wake sequence
  // ****************************************************************
  dwsc_state_type state_q;
  logic [21:0] cnt_q;
  logic [12:0] div_q;
  logic restart_q;
  logic tick;
  logic drx_on;
  logic [21:0] off_ticks;
  logic [15:0] off_val;

  assign drx_on = config_q[`DWSC_CFG_DRX];
  assign off_val = {off_hi_q, off_lo_q};
  // Prescale codes give 1, 4, 16 or 64 base ticks per count.
  assign off_ticks = 22'({off_val, 6'b000000} >> (6 -
    2 * {config_q[`DWSC_CFG_PS_HI], config_q[`DWSC_CFG_PS_LO]}));
  assign tick = (div_q == 13'(TICK_CYCLES - 1));

  // The divider restarts one cycle into the off, recovery and settle phases, so the first tick is a full one unless a tick falls in that cycle.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 13'd0;
    end else if (restart_q || tick) begin
      div_q <= 13'd0;
    end else begin
      div_q <= div_q + 13'd1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= DWSC_IDLE;
      cnt_q <= 22'd0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (!drx_on) begin
        state_q <= DWSC_IDLE;
      end else begin
        unique case (state_q)
          DWSC_IDLE: begin
            state_q <= DWSC_OFF;
            cnt_q <= off_ticks;
            restart_q <= 1'b1;
          end
          DWSC_OFF: begin
            if (cnt_q == 22'd0) begin
              state_q <= DWSC_CPU;
              cnt_q <= {14'd0, cpu_q};
              restart_q <= 1'b1;
            end else if (tick) begin
              cnt_q <= cnt_q - 22'd1;
            end
          end
          DWSC_CPU: begin
            if (cnt_q == 22'd0) begin
              state_q <= DWSC_RF;
              cnt_q <= {6'd0, rf_hi_q, rf_lo_q};
              restart_q <= 1'b1;
            end else if (tick) begin
              cnt_q <= cnt_q - 22'd1;
            end
          end
          DWSC_RF: begin
            if (cnt_q == 22'd0) begin
              state_q <= DWSC_ON;
            end else if (tick) begin
              cnt_q <= cnt_q - 22'd1;
            end
          end
          DWSC_ON: begin
            // A host that lets the line rise sends the device back to sleep.
            if (wake_rise) begin
              state_q <= DWSC_OFF;
              cnt_q <= off_ticks;
              restart_q <= 1'b1;
            end
          end
          default: state_q <= DWSC_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic drive_low;
  logic awake;
  logic fpin_rd;
  logic apin_rd;
  assign drive_low = (state_q == DWSC_CPU) || (state_q == DWSC_RF);
  assign awake = (state_q == DWSC_IDLE) || (state_q == DWSC_ON);
  assign fpin_rd = rd_act_q && config_q[`DWSC_CFG_FOUT];
  assign apin_rd = rd_act_q && config_q[`DWSC_CFG_AOUT];

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wake_handshake_line_out <= 1'b0;
      wake_handshake_line_oe_out <= 1'b0;
    end else if (drive_low) begin
      wake_handshake_line_out <= 1'b0;
      wake_handshake_line_oe_out <= 1'b1;
    end else begin
      wake_handshake_line_out <= rd_bit_q;
      wake_handshake_line_oe_out <= rd_act_q && !fpin_rd && !apin_rd;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      amplitude_data_pin_out <= 1'b0;
      amplitude_data_pin_oe_out <= 1'b0;
      frequency_data_pin_out <= 1'b0;
      frequency_data_pin_oe_out <= 1'b0;
    end else begin
      amplitude_data_pin_out <= apin_rd ? rd_bit_q : amp_demod_in;
      frequency_data_pin_out <= fpin_rd ? rd_bit_q : freq_demod_in;
      amplitude_data_pin_oe_out <= apin_rd || awake;
      frequency_data_pin_oe_out <= fpin_rd || awake;
    end
  end

  // Peak detectors stay off through the settle phase to spare their caps.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      power_out <= '0;
      deep_sleep_out <= 1'b0;
    end else begin
      deep_sleep_out <= power_q[`DWSC_PWR_SLEEP];
      if (power_q[`DWSC_PWR_SLEEP] || !(awake || state_q == DWSC_RF)) begin
        power_out <= '0;
      end else if (state_q == DWSC_RF) begin
        power_out <= power_q[7:1] & 7'b1111010;
      end else begin
        power_out <= power_q[7:1];
      end
    end
  end

  // With the gain frozen nothing moves it; the AGC steers it when running.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gain_q <= 1'b1;
    end else if (control_q[`DWSC_CTL_FREEZE]) begin
      gain_q <= gain_q;
    end else if (soft_rst) begin
      gain_q <= 1'b1;
    end else if (wr_stb && wr_addr == `DWSC_ADDR_CONFIG) begin
      gain_q <= wr_data[`DWSC_CFG_GAIN];
    end else if (power_q[6]) begin
      gain_q <= agc_gain_high_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      analog_ctl_out <= '0;
      osc_freq_out <= 8'h00;
    end else begin
      analog_ctl_out.gain_freeze <= control_q[`DWSC_CTL_FREEZE];
      analog_ctl_out.freq_detector_tracking <=
        control_q[`DWSC_CTL_FTRK];
      analog_ctl_out.amp_detector_tracking <=
        control_q[`DWSC_CTL_ATRK];
      analog_ctl_out.lna_gain_high <= gain_q;
      analog_ctl_out.accurate_freq_cal_select <=
        config_q[`DWSC_CFG_ACCCAL];
      osc_freq_out <= osc_q;
    end
  end

endmodule // dwsc_top

/* File: bench/dwsc_host_model.sv */
// Purpose: Host model on the serial bus and the shared wake line.
// Assumes: Tasks are entered just after a falling clock edge.
// Notes: low_out pulls the open-drain line; a pull-up gives high.
`timescale 1ns/1ps
`include "dwsc_regs.svh"
module dwsc_host_model (
  input wire logic clk_in,
  input wire logic line_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic low_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    low_out = 1'b0;
  end
  // Half periods of 10 clocks stay clear of the 8 clock minimum.
  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    logic rx;
    rd = 8'h00;
    rx = (w[15:12] == `DWSC_CMD_READ);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sclk_out = 1'b0;
      low_out = ~w[i] & ~(rx & (i < 8));
      repeat (10) @(negedge clk_in);
      rd = {rd[6:0], line_in};
      sclk_out = 1'b1;
      repeat (10) @(negedge clk_in);
    end
    low_out = 1'b0;
    cs_n_out = 1'b1;
    repeat (12) @(negedge clk_in);
  endtask
  task automatic hold(input logic en);
    low_out = en;
  endtask
endmodule // dwsc_host_model

/* File: bench/dwsc_top_asserts.sv */
// Purpose: Port checker for the wake sequencer.
// Assumes: Serial bus quiet for 10 clocks before a wake check.
// Notes: Read frames also drive the wake line, hence the quiet gate.
`timescale 1ns/1ps
module dwsc_top_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic chip_select_n_in,
  input wire logic wake_handshake_line_in,
  input wire logic wake_handshake_line_out,
  input wire logic wake_handshake_line_oe_out,
  input wire logic amplitude_data_pin_oe_out,
  input wire logic frequency_data_pin_oe_out,
  input wire dwsc_pkg::dwsc_power_type power_out
);
  import dwsc_pkg::*;
  logic [3:0] idle_q;
  logic oe, wi, dat;
  assign oe = wake_handshake_line_oe_out;
  assign wi = wake_handshake_line_in;
  assign dat = amplitude_data_pin_oe_out & frequency_data_pin_oe_out;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) idle_q <= 4'h0;
    else if (!chip_select_n_in) idle_q <= 4'h0;
    else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
  end
  // ********
  // Wake sequence
  // ********
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_wake_pull_low: assert property (oe && idle_q > 9 |->
    !wake_handshake_line_out) else $error("wake line not low");
  a_cpu_unpowered: assert property ($rose(oe) && idle_q > 9 |->
    power_out == '0) else $error("powered in recovery");
  a_wake_held: assert property ($rose(oe) && idle_q > 9 |->
    oe [*6]) else $error("wake drive too short");
  a_settle_no_peak: assert property (oe && idle_q > 9 |->
    !power_out.freq_peak_detect_on && !power_out.amp_peak_detect_on)
    else $error("peak detector on in settle");
  a_settle_data_off: assert property (oe && idle_q > 9 |->
    !amplitude_data_pin_oe_out && !frequency_data_pin_oe_out)
    else $error("data pin on in settle");
  a_release_data_on: assert property ($fell(oe) && idle_q > 9 |->
    ##[0:2] dat) else $error("data pins not enabled");
  a_lost_host_off: assert property ($fell(oe) && idle_q > 9 ##1 wi |->
    ##[0:7] power_out == '0) else $error("no power down");
  a_hold_keeps_on: assert property (dat && !oe && !wi &&
    $past(wi, 4) == 1'b0 && idle_q > 9 |=> $stable(power_out))
    else $error("power changed while held");
  c_wake: cover property ($rose(oe) && idle_q > 9);
  c_release: cover property ($fell(oe) && idle_q > 9 ##1 !wi);
  c_lost: cover property ($fell(oe) && idle_q > 9 ##1 wi);
endmodule // dwsc_top_asserts
bind dwsc_top dwsc_top_asserts dwsc_top_asserts_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .chip_select_n_in(chip_select_n_in),
  .wake_handshake_line_in(wake_handshake_line_in),
  .wake_handshake_line_out(wake_handshake_line_out),
  .wake_handshake_line_oe_out(wake_handshake_line_oe_out),
  .amplitude_data_pin_oe_out(amplitude_data_pin_oe_out),
  .frequency_data_pin_oe_out(frequency_data_pin_oe_out),
  .power_out(power_out));

/* File: bench/dwsc_top_tb_top.sv */
// Purpose: Self-checking bench for the wake sequencer.
// Assumes: Tick cut to 4 clocks; off period 256 x prescale 4 ticks.
// Notes: All inputs change at falling clock edges.
`timescale 1ns/1ps
`include "dwsc_regs.svh"
module dwsc_top_tb_top;
  import dwsc_pkg::*;
  logic clk, rst, sclk, cs_n, h_low, line, w_out, w_oe;
  logic a_out, a_oe, f_out, f_oe, sleep;
  logic [3:0] cnt = 4'h0;
  logic pin_sel = 1'b0;
  logic [7:0] osc, rd;
  dwsc_power_type pwr;
  dwsc_analog_ctl_type actl;
  int mismatches = 0;
  int checked = 0;
  int n;
  // Columns: write, address, write data, expected read.
  logic [20:0] rows [13] = '{{1'b0, 4'h0, 8'h00, 8'h00},
    {1'b0, 4'h1, 8'h00, 8'h40}, {1'b0, 4'h2, 8'h00, 8'h00},
    {1'b0, 4'h6, 8'h00, 8'h00}, {1'b0, 4'h7, 8'h00, 8'h00},
    {1'b0, 4'h8, 8'h00, 8'h00}, {1'b1, 4'h6, 8'hA5, 8'hA5},
    {1'b1, 4'h7, 8'h5A, 8'h5A}, {1'b1, 4'h8, 8'h03, 8'h03},
    {1'b1, 4'h4, 8'h01, 8'h01}, {1'b1, 4'h5, 8'hC3, 8'hC3},
    {1'b1, 4'hB, 8'h55, 8'h00}, {1'b1, 4'h2, 8'h4C, 8'h4C}};
  assign line = ~((w_oe & ~w_out) | h_low);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) cnt <= cnt + 4'h1;
  dwsc_top #(.TICK_CYCLES(4), .ACAL_CYCLES(2000),
    .PCAL_CYCLES(8)) dwsc_top_i (.clk_sys_in(clk), .rst_in(rst),
    .serial_clk_in(sclk), .chip_select_n_in(cs_n),
    .wake_handshake_line_in(line), .wake_handshake_line_out(w_out),
    .wake_handshake_line_oe_out(w_oe), .amp_demod_in(cnt[0]),
    .freq_demod_in(cnt[1]), .agc_gain_high_in(cnt[2]),
    .amplitude_data_pin_out(a_out), .amplitude_data_pin_oe_out(a_oe),
    .frequency_data_pin_out(f_out), .frequency_data_pin_oe_out(f_oe),
    .power_out(pwr), .deep_sleep_out(sleep), .analog_ctl_out(actl),
    .osc_freq_out(osc));
  dwsc_host_model dwsc_host_model_i (.clk_in(clk),
    .line_in(pin_sel ? f_out : line),
    .sclk_out(sclk), .cs_n_out(cs_n), .low_out(h_low));
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED %0t count %0d", $time, got);
    end
  endtask
  // Waits for the wake enable (sel 0) or any power (sel 1) to reach lvl.
  task automatic wait_on(input int sel, input logic lvl, output int c);
    c = 0;
    while (((sel == 0) ? w_oe : (pwr != '0)) !== lvl) begin
      @(negedge clk);
      c++;
      if (c > 6000) begin
        mismatches++;
        results();
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    dwsc_host_model_i.frame({`DWSC_CMD_WRITE, a, d}, rd);
  endtask
  task automatic rr(input logic [3:0] a);
    dwsc_host_model_i.frame({`DWSC_CMD_READ, a, 8'h00}, rd);
  endtask
  initial begin
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'({pwr, a_oe, w_oe}), 16'h0002);
    for (int i = 0; i < 13; i++) begin
      if (rows[i][20]) wr(rows[i][19:16], rows[i][15:8]);
      rr(rows[i][19:16]);
      chk(16'(rd), 16'(rows[i][7:0]));
    end
    chk(16'(actl), 16'h001E);
    wr(4'h0, 8'hFE);
    chk(16'({pwr, sleep}), 16'h00FE);
    wr(4'h0, 8'h01);
    chk(16'({pwr, sleep}), 16'h0001);
    wr(4'h3, 8'h5F);
    chk(16'(osc), 16'h005F);
    wr(4'h1, 8'h60);
    wr(4'h2, 8'h01);
    rr(4'h9);
    chk(16'(rd[0]), 16'h0000);
    repeat (2000) @(negedge clk);
    rr(4'h9);
    chk(16'(rd[1:0]), 16'h0001);
    wr(4'h2, 8'h02);
    rr(4'h2);
    chk(16'(rd), 16'h0000);
    rr(4'h9);
    chk(16'(rd[1:0]), 16'h0003);
    dwsc_host_model_i.frame(16'h3000, rd);
    rr(4'h6);
    chk(16'(rd), 16'h0000);
    wr(4'h0, 8'hFE);
    wr(4'h4, 8'h01);
    wr(4'h6, 8'h02);
    wr(4'h8, 8'h03);
    wr(4'h1, 8'h03);
    wait_on(0, 1'b1, n);
    chk(16'(pwr), 16'h0000);
    wait_on(1, 1'b1, n);
    chk_rng(n, 8, 11);
    chk(16'({pwr, a_oe, f_oe}), 16'h01E8);
    dwsc_host_model_i.hold(1'b1);
    wait_on(0, 1'b0, n);
    chk_rng(n, 12, 15);
    repeat (2) @(negedge clk);
    chk(16'({pwr, a_oe, f_oe}), 16'h01FF);
    repeat (50) @(negedge clk);
    chk(16'(pwr), 16'h007F);
    dwsc_host_model_i.hold(1'b0);
    wait_on(1, 1'b0, n);
    chk_rng(n, 1, 8);
    wait_on(0, 1'b1, n);
    chk_rng(n, 4092, 4102);
    wait_on(0, 1'b0, n);
    wait_on(1, 1'b0, n);
    chk_rng(n, 1, 8);
    chk(16'({a_oe, w_oe}), 16'h0000);
    wait_on(0, 1'b1, n);
    chk_rng(n, 4092, 4102);
    wait_on(0, 1'b0, n);
    repeat (10) @(negedge clk);
    wr(4'h1, 8'h00);
    repeat (2) @(negedge clk);
    chk(16'({pwr, a_oe, w_oe}), 16'h01FE);
    wr(4'h1, 8'h10);
    pin_sel = 1'b1;
    rr(4'h6);
    pin_sel = 1'b0;
    chk(16'(rd), 16'h0002);
    results();
  end
endmodule // dwsc_top_tb_top
